/* File: psi_defines.svh */
/*
  Constants of the PHY status and interrupt register group: register offsets,
  field positions, reset values and frame counts of the management interface.
  Assumes it is included by bare name by every file that needs these values.
*/
`ifndef PSI_DEFINES_SVH
`define PSI_DEFINES_SVH

// Register offsets on the management interface
`define PSI_REG_LINK_STATUS 5'h11
`define PSI_REG_INT_ENABLE  5'h12
`define PSI_REG_INT_FLAGS   5'h13

// Fields of phy_link_status
`define PSI_B_SPEED_HI  15
`define PSI_B_SPEED_LO  14
`define PSI_B_DUPLEX    13
`define PSI_B_PAGE      12
`define PSI_B_RESOLVED  11
`define PSI_B_LINK      10
`define PSI_B_XOVER     6
`define PSI_B_DOWNGRADE 5
`define PSI_B_TX_PAUSE  3
`define PSI_B_RX_PAUSE  2
`define PSI_B_POLARITY  1
`define PSI_B_JABBER    0

// Fields of interrupt_flags and interrupt_enable
`define PSI_I_AN_ERR    15
`define PSI_I_SPEED     14
`define PSI_I_DUPLEX    13
`define PSI_I_PAGE      12
`define PSI_I_LINK_LOST 11
`define PSI_I_LINK_UP   10
`define PSI_I_WAKE      6
`define PSI_I_DOWNGRADE 5
`define PSI_I_POLARITY  1
`define PSI_I_JABBER    0
`define PSI_INT_IMPL_MASK 16'hfc63

// Reset values
`define PSI_ENABLE_RESET 16'h0000
`define PSI_FLAGS_RESET  16'h0000
`define PSI_XOVER_RESET  2'h3

// crossover_config encodings
`define PSI_XOVER_MDI  2'h0
`define PSI_XOVER_MDIX 2'h1
`define PSI_XOVER_AUTO 2'h3

// Management frame fields and bit counts
`define PSI_OP_READ      2'h2
`define PSI_OP_WRITE     2'h1
`define PSI_PREAMBLE_LEN 6'h20
`define PSI_OP_LAST      6'h01
`define PSI_ADDR_LAST    6'h09
`define PSI_DATA_LAST    6'h0f

`endif

/* File: psi_pkg.sv */
/*
  Types of the PHY status and interrupt register group.
  Assumes nothing beyond the constants header.
*/
package psi_pkg;
  // Management frame decoder states, Gray coded along the frame
  typedef enum logic [2:0] {
    PSI_ST_PRE    = 3'h0,
    PSI_ST_START  = 3'h1,
    PSI_ST_OPCODE = 3'h3,
    PSI_ST_ADDR   = 3'h2,
    PSI_ST_TURN   = 3'h6,
    PSI_ST_DATA   = 3'h7
  } psi_frame_state_t;

  typedef logic [15:0] psi_word_t;
  typedef logic [4:0]  psi_regaddr_t;
endpackage

/* File: psi_mgmt_if.sv */
/*
  Carrier between the management frame decoder and the register group.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ns
interface psi_mgmt_if;
  import psi_pkg::*;
  logic         bit_stb;   // One pulse per sampled clock rise
  logic         bit_val;   // Data level at that rise
  logic         rd_stb;    // Register read request
  logic         wr_stb;    // Register write request
  psi_regaddr_t reg_addr;
  psi_word_t    wr_data;
  psi_word_t    rd_data;
  logic         mdio_out;
  logic         mdio_oe;

  modport engine (
    input  bit_stb, bit_val, rd_data,
    output rd_stb, wr_stb, reg_addr, wr_data, mdio_out, mdio_oe
  );
  modport regs (
    output bit_stb, bit_val, rd_data,
    input  rd_stb, wr_stb, reg_addr, wr_data, mdio_out, mdio_oe
  );
endinterface

/* File: psi_mdio_frame.sv */
/*
  Serial management frame decoder: preamble, start, opcode, addresses,
  turnaround and sixteen data bits, driving read data back on the data pin.
  Assumes sampled clock rises and data levels from the register group, and a
  read answer on rd_data in the same cycle as rd_stb.
*/
`timescale 1ns/1ns
`include "psi_defines.svh"
module psi_mdio_frame
  import psi_pkg::*;
(
  // Clock and reset
  input  logic       clk_i,
  input  logic       arst_n_i,
  // Strapped device address, static in operation
  input  logic [4:0] phy_addr_i,
  // Toward the register group
  psi_mgmt_if.engine mgmt
);

  psi_frame_state_t state, next_state;
  logic [5:0]       cnt, next_cnt;
  logic [1:0]       op, next_op;
  logic [9:0]       adr, next_adr;
  psi_word_t        shreg, next_shreg;
  psi_word_t        wr_data, next_wr_data;
  logic             mine, next_mine;
  logic             rd_stb, next_rd_stb;
  logic             wr_stb, next_wr_stb;
  logic             out, next_out;
  logic             oe, next_oe;

  // Frame walk; a frame for another address is followed but never answered
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_op      = op;
    next_adr     = adr;
    next_shreg   = shreg;
    next_wr_data = wr_data;
    next_mine    = mine;
    next_rd_stb  = 1'b0;
    next_wr_stb  = 1'b0;
    next_out     = out;
    next_oe      = oe;
    if (mgmt.rd_stb) begin
      next_shreg = mgmt.rd_data;
    end
    if (mgmt.bit_stb) begin
      case (state)
        PSI_ST_PRE: begin
          if (mgmt.bit_val) begin
            if (cnt != `PSI_PREAMBLE_LEN) begin
              next_cnt = cnt + 6'h01;
            end
          end else begin
            if (cnt == `PSI_PREAMBLE_LEN) begin
              next_state = PSI_ST_START;
            end
            next_cnt = 6'h00;
          end
        end
        PSI_ST_START: begin
          next_state = mgmt.bit_val ? PSI_ST_OPCODE : PSI_ST_PRE;
        end
        PSI_ST_OPCODE: begin
          next_op = {op[0], mgmt.bit_val};
          if (cnt == `PSI_OP_LAST) begin
            next_state = PSI_ST_ADDR;
            next_cnt   = 6'h00;
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
        PSI_ST_ADDR: begin
          next_adr = {adr[8:0], mgmt.bit_val};
          if (cnt == `PSI_ADDR_LAST) begin
            next_state  = PSI_ST_TURN;
            next_cnt    = 6'h00;
            next_mine   = (next_adr[9:5] == phy_addr_i) &&
                          ((op == `PSI_OP_READ) || (op == `PSI_OP_WRITE));
            next_rd_stb = next_mine && (op == `PSI_OP_READ);
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
        PSI_ST_TURN: begin
          if (cnt == 6'h00) begin
            next_cnt = 6'h01;
            if (mine && (op == `PSI_OP_READ)) begin
              next_oe  = 1'b1;  // Second turnaround bit driven low
              next_out = 1'b0;
            end
          end else begin
            next_state = PSI_ST_DATA;
            next_cnt   = 6'h00;
            if (mine && (op == `PSI_OP_READ)) begin
              next_out   = shreg[15];
              next_shreg = {shreg[14:0], 1'b0};
            end
          end
        end
        PSI_ST_DATA: begin
          if (op == `PSI_OP_READ) begin
            next_out   = shreg[15];
            next_shreg = {shreg[14:0], 1'b0};
          end else begin
            next_shreg = {shreg[14:0], mgmt.bit_val};
          end
          if (cnt == `PSI_DATA_LAST) begin
            next_state = PSI_ST_PRE;
            next_cnt   = 6'h00;
            next_oe    = 1'b0;
            next_out   = 1'b0;
            next_mine  = 1'b0;
            if (mine && (op == `PSI_OP_WRITE)) begin
              next_wr_stb  = 1'b1;
              next_wr_data = {shreg[14:0], mgmt.bit_val};
            end
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
        default: begin
          next_state = PSI_ST_PRE;
          next_cnt   = 6'h00;
          next_oe    = 1'b0;
        end
      endcase
    end
  end

  // Frame state registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state   <= PSI_ST_PRE;
      cnt     <= 6'h00;
      op      <= 2'h0;
      adr     <= 10'h000;
      shreg   <= 16'h0000;
      wr_data <= 16'h0000;
      mine    <= 1'b0;
      rd_stb  <= 1'b0;
      wr_stb  <= 1'b0;
      out     <= 1'b0;
      oe      <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      op      <= next_op;
      adr     <= next_adr;
      shreg   <= next_shreg;
      wr_data <= next_wr_data;
      mine    <= next_mine;
      rd_stb  <= next_rd_stb;
      wr_stb  <= next_wr_stb;
      out     <= next_out;
      oe      <= next_oe;
    end
  end

  // Outputs toward the register group, all from flops
  assign mgmt.rd_stb   = rd_stb;
  assign mgmt.wr_stb   = wr_stb;
  assign mgmt.reg_addr = adr[4:0];
  assign mgmt.wr_data  = wr_data;
  assign mgmt.mdio_out = out;
  assign mgmt.mdio_oe  = oe;

endmodule

/* File: psi_phy_status_regs.sv */
/*
  Status and interrupt register group of a 10/100 PHY: live link status,
  latched event flags with per-event enables, and an active-low interrupt pin,
  read and written over the serial management pins.
  Assumes PHY core status inputs on clk_i; management pins are asynchronous.
*/
`timescale 1ns/1ns
`include "psi_defines.svh"
module psi_phy_status_regs
  import psi_pkg::*;
(
  // Clock and reset
  input  logic       clk_i,
  input  logic       arst_n_i,
  // Management pins
  input  logic       mdc_i,
  input  logic       mdio_i,
  output logic       mdio_o,
  output logic       mdio_oe_o,
  input  logic [4:0] phy_addr_i,
  // PHY core status
  input  logic [1:0] speed_i,
  input  logic       full_duplex_i,
  input  logic       link_up_i,
  input  logic       an_enable_i,
  input  logic       an_complete_i,
  input  logic       tx_pause_i,
  input  logic       rx_pause_i,
  input  logic       polarity_rev_i,
  input  logic       jabber_i,
  input  logic       downgrade_i,
  input  logic       auto_mdix_i,
  // PHY core events, one-cycle pulses
  input  logic       page_rx_i,
  input  logic       an_error_i,
  input  logic       wake_i,
  // Crossover configuration and software reset
  input  logic [1:0] crossover_config_i,
  input  logic       soft_reset_i,
  // Interrupt pin
  output logic       int_n_o
);

  localparam psi_word_t IMPL = `PSI_INT_IMPL_MASK;

  psi_mgmt_if mgmt ();

  logic [2:0] mdc_sync, mdio_sync;
  logic       mdc_level, next_mdc_level;
  logic       mdio_level, next_mdio_level;
  logic       bit_stb, next_bit_stb;
  logic       bit_val, next_bit_val;
  psi_word_t  link_status, next_link_status;
  psi_word_t  int_enable, next_int_enable;
  psi_word_t  flags, next_flags;
  psi_word_t  events;
  logic       page_seen, next_page_seen;
  logic [1:0] xover_applied, next_xover_applied;
  logic       xover_bit, resolved, flag_clear, status_read;
  logic [1:0] prev_speed;
  logic       prev_duplex, prev_link, prev_pol, prev_jab, prev_dg, primed;
  logic       int_n, next_int_n;

  // Three-stage pin sampling; only the later two stages decide a change
  always_comb begin
    next_mdc_level  = (mdc_sync[1] == mdc_sync[2]) ? mdc_sync[2] : mdc_level;
    next_mdio_level = (mdio_sync[1] == mdio_sync[2]) ? mdio_sync[2] : mdio_level;
    next_bit_stb    = next_mdc_level & ~mdc_level;
    next_bit_val    = next_mdio_level;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Idle pin levels, so a clock resting high gives no false rise
      mdc_sync   <= 3'h7;
      mdio_sync  <= 3'h7;
      mdc_level  <= 1'b1;
      mdio_level <= 1'b1;
      bit_stb    <= 1'b0;
      bit_val    <= 1'b0;
    end else begin
      mdc_sync   <= {mdc_sync[1:0], mdc_i};
      mdio_sync  <= {mdio_sync[1:0], mdio_i};
      mdc_level  <= next_mdc_level;
      mdio_level <= next_mdio_level;
      bit_stb    <= next_bit_stb;
      bit_val    <= next_bit_val;
    end
  end

  assign mgmt.bit_stb = bit_stb;
  assign mgmt.bit_val = bit_val;
  assign mdio_o       = mgmt.mdio_out;
  assign mdio_oe_o    = mgmt.mdio_oe;

  // Frame decoder
  psi_mdio_frame u_frame (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .phy_addr_i (phy_addr_i),
    .mgmt       (mgmt.engine)
  );

  assign status_read = mgmt.rd_stb && (mgmt.reg_addr == `PSI_REG_LINK_STATUS);
  // Soft reset clears flags too, but a same-cycle event still lands
  assign flag_clear  = (mgmt.rd_stb && (mgmt.reg_addr == `PSI_REG_INT_FLAGS)) ||
                       soft_reset_i;

  // Live status word; pause bits raise no event flag
  always_comb begin
    resolved = !an_enable_i || an_complete_i;
    case (xover_applied)
      `PSI_XOVER_MDI:  xover_bit = 1'b0;
      `PSI_XOVER_MDIX: xover_bit = 1'b1;
      `PSI_XOVER_AUTO: xover_bit = auto_mdix_i;
      default:         xover_bit = 1'b0;  // Reserved setting reads straight
    endcase
    next_link_status = 16'h0000;
    next_link_status[`PSI_B_SPEED_HI:`PSI_B_SPEED_LO] = speed_i;
    next_link_status[`PSI_B_DUPLEX]    = full_duplex_i;
    next_link_status[`PSI_B_LINK]      = link_up_i;
    next_link_status[`PSI_B_PAGE]      = page_seen;
    next_link_status[`PSI_B_RESOLVED]  = resolved;
    next_link_status[`PSI_B_XOVER]     = resolved & xover_bit;
    next_link_status[`PSI_B_DOWNGRADE] = downgrade_i;
    // Forced mode holds pause at zero; needs finished negotiation
    next_link_status[`PSI_B_TX_PAUSE]  = an_enable_i & an_complete_i & tx_pause_i;
    next_link_status[`PSI_B_RX_PAUSE]  = an_enable_i & an_complete_i & rx_pause_i;
    next_link_status[`PSI_B_POLARITY]  = polarity_rev_i;
    next_link_status[`PSI_B_JABBER]    = jabber_i;
  end

  // Event detection; primed keeps reset-time levels from looking like changes
  always_comb begin
    events = 16'h0000;
    events[`PSI_I_AN_ERR] = an_error_i;
    events[`PSI_I_PAGE]   = page_rx_i;
    events[`PSI_I_WAKE]   = wake_i;
    if (primed) begin
      events[`PSI_I_SPEED]     = speed_i != prev_speed;
      events[`PSI_I_DUPLEX]    = full_duplex_i != prev_duplex;
      events[`PSI_I_LINK_LOST] = prev_link & ~link_up_i;
      events[`PSI_I_LINK_UP]   = ~prev_link & link_up_i;
      events[`PSI_I_DOWNGRADE] = downgrade_i & ~prev_dg;
      events[`PSI_I_POLARITY]  = polarity_rev_i != prev_pol;
      events[`PSI_I_JABBER]    = jabber_i & ~prev_jab;
    end
  end

  // Sticky flags, set wins over a clear in the same cycle
  generate
    for (genvar gi = 0; gi < 16; gi++) begin : g_flag
      assign next_flags[gi] = IMPL[gi] & (events[gi] | (flags[gi] & ~flag_clear));
    end
  endgenerate

  // Enables, page latch, crossover capture and interrupt level
  always_comb begin
    next_int_enable = int_enable;
    if (soft_reset_i) begin
      next_int_enable = `PSI_ENABLE_RESET;
    end else if (mgmt.wr_stb && (mgmt.reg_addr == `PSI_REG_INT_ENABLE)) begin
      next_int_enable = mgmt.wr_data;
    end
    next_page_seen     = page_rx_i | (page_seen & ~(status_read | soft_reset_i));
    next_xover_applied = soft_reset_i ? crossover_config_i : xover_applied;
    next_int_n         = ~|(flags & int_enable);
  end

  // Read answer; unmapped offsets read as zero
  always_comb begin
    case (mgmt.reg_addr)
      `PSI_REG_LINK_STATUS: mgmt.rd_data = link_status;
      `PSI_REG_INT_ENABLE:  mgmt.rd_data = int_enable;
      `PSI_REG_INT_FLAGS:   mgmt.rd_data = flags;
      default:              mgmt.rd_data = 16'h0000;
    endcase
  end

  // Register state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_status   <= 16'h0000;
      int_enable    <= `PSI_ENABLE_RESET;
      flags         <= `PSI_FLAGS_RESET;
      page_seen     <= 1'b0;
      xover_applied <= `PSI_XOVER_RESET;
      int_n         <= 1'b1;
      prev_speed    <= 2'h0;
      prev_duplex   <= 1'b0;
      prev_link     <= 1'b0;
      prev_pol      <= 1'b0;
      prev_jab      <= 1'b0;
      prev_dg       <= 1'b0;
      primed        <= 1'b0;
    end else begin
      link_status   <= next_link_status;
      int_enable    <= next_int_enable;
      flags         <= next_flags;
      page_seen     <= next_page_seen;
      xover_applied <= next_xover_applied;
      int_n         <= next_int_n;
      prev_speed    <= speed_i;
      prev_duplex   <= full_duplex_i;
      prev_link     <= link_up_i;
      prev_pol      <= polarity_rev_i;
      prev_jab      <= jabber_i;
      prev_dg       <= downgrade_i;
      primed        <= 1'b1;
    end
  end

  assign int_n_o = int_n;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_flags_read;
    mgmt.rd_stb && (mgmt.reg_addr == `PSI_REG_INT_FLAGS) && !soft_reset_i;
  endsequence
  sequence s_status_read;
    mgmt.rd_stb && (mgmt.reg_addr == `PSI_REG_LINK_STATUS);
  endsequence

  AST_PAGE_LATCH:
    assert property (page_rx_i |=> page_seen ##1 link_status[`PSI_B_PAGE])
      else $error("page bit not latched");
  AST_PAGE_CLEAR:
    assert property ((s_status_read ##0 !page_rx_i) |=> !page_seen)
      else $error("page bit not cleared by status read");
  AST_RESOLVED:
    assert property (primed |=> link_status[`PSI_B_RESOLVED] == $past(resolved))
      else $error("resolved bit wrong");
  AST_XOVER_HOLD:
    assert property (!soft_reset_i |=> $stable(xover_applied))
      else $error("crossover changed without soft reset");
  AST_PAUSE_FORCED:
    assert property (!an_enable_i |=> link_status[3:2] == 2'h0)
      else $error("pause bits set in forced mode");
  AST_POLARITY:
    assert property (1'b1 |=> link_status[`PSI_B_POLARITY] == $past(polarity_rev_i))
      else $error("polarity bit wrong");
  AST_AN_ERR:
    assert property (an_error_i |=> flags[`PSI_I_AN_ERR])
      else $error("negotiation error flag missed");
  AST_FLAG_CLEAR:
    assert property ((s_flags_read ##0 (events == 16'h0000)) |=> flags == 16'h0000)
      else $error("flags not cleared by read");
  AST_SET_WINS:
    assert property ((flag_clear && events[`PSI_I_LINK_LOST]) |=> flags[`PSI_I_LINK_LOST])
      else $error("link lost flag lost to clear");
  AST_LINK_UP:
    assert property ((primed && !prev_link && link_up_i) |=> flags[`PSI_I_LINK_UP])
      else $error("link up flag missed");
  AST_ENABLE_WRITE:
    assert property ((mgmt.wr_stb && mgmt.reg_addr == `PSI_REG_INT_ENABLE && !soft_reset_i)
                     |=> int_enable == $past(mgmt.wr_data))
      else $error("enable write not stored");
  AST_IRQ_SET:
    assert property ((|(flags & int_enable)) |=> !int_n_o)
      else $error("interrupt not asserted");
  AST_IRQ_REL:
    assert property ((flags & int_enable) == 16'h0000 |=> int_n_o)
      else $error("interrupt not released");

endmodule

/* File: psi_mdio_host.sv */
/*
  Management host model: drives clock and data pins, reads answers back.
  Assumes a pull-up on the data wire and the 10 MHz core clock.
*/
`timescale 1ns/1ns
module psi_mdio_host (
  // Core clock
  input  logic clk_i,
  // Device side of the data pin
  input  logic dev_o_i,
  input  logic dev_oe_i,
  // Pins toward the device
  output logic mdc_o,
  output logic wire_o
);
  logic drv;
  logic val;

  // Released wire floats to the pull-up level
  assign wire_o = dev_oe_i ? dev_o_i : (drv ? val : 1'b1);

  initial begin
    mdc_o = 1'b1;
    drv   = 1'b0;
    val   = 1'b1;
  end

  // One bit of 800 ns: data changes with the fall, sampled at the rise
  task automatic bit_cyc(input logic d, input logic v, output logic s);
    @(posedge clk_i);
    mdc_o <= 1'b0;
    drv   <= d;
    val   <= v;
    repeat (4) @(posedge clk_i);
    s = wire_o;
    mdc_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  // Whole frame; clock stands high between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    logic        host;
    hdr  = {2'b01, op, pa, ra};
    host = (op != 2'h2);
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    bit_cyc(host, 1'b1, s);
    bit_cyc(host, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(host, wd[i], s);
      rd[i] = s;
    end
    @(posedge clk_i);
    drv <= 1'b0;
  endtask
endmodule

/* File: psi_phy_status_regs_tb.sv */
/*
  Self-checking bench of the status and interrupt registers.
  Assumes the host model and a 10 MHz core clock.
*/
`timescale 1ns/1ns
`include "psi_defines.svh"
module psi_phy_status_regs_tb;
  import psi_pkg::*;
  logic       clk_i, arst_n_i, mdc, mdio_w, mdio_o, mdio_oe, int_n;
  logic [1:0] speed, xcfg;
  logic       dup, link, an_en, an_done, txp, rxp, pol, jab, dg, mdix;
  logic       page, an_err, wake, srst;
  int         fails, tests_run;
  localparam logic [4:0] PHY_ADDR = 5'h03;

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  psi_phy_status_regs u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .phy_addr_i(PHY_ADDR),
    .speed_i(speed), .full_duplex_i(dup), .link_up_i(link), .an_enable_i(an_en),
    .an_complete_i(an_done), .tx_pause_i(txp), .rx_pause_i(rxp),
    .polarity_rev_i(pol), .jabber_i(jab), .downgrade_i(dg), .auto_mdix_i(mdix),
    .page_rx_i(page), .an_error_i(an_err), .wake_i(wake),
    .crossover_config_i(xcfg), .soft_reset_i(srst), .int_n_o(int_n));

  psi_mdio_host u_host (.clk_i(clk_i), .dev_o_i(mdio_o), .dev_oe_i(mdio_oe),
                        .mdc_o(mdc), .wire_o(mdio_w));

  task automatic check(input string nm, input psi_word_t seen, input psi_word_t exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input psi_regaddr_t a, input psi_word_t d);
    psi_word_t unused;
    u_host.frame(`PSI_OP_WRITE, PHY_ADDR, a, d, unused);
  endtask

  task automatic rc(input psi_regaddr_t a, input psi_word_t exp, input string nm);
    psi_word_t d;
    u_host.frame(`PSI_OP_READ, PHY_ADDR, a, 16'h0000, d);
    check(nm, d, exp);
  endtask

  task automatic pin(input logic exp);
    repeat (4) @(posedge clk_i);
    check("int pin", {15'h0000, int_n}, {15'h0000, exp});
  endtask

  task automatic t_regs;
    psi_word_t d;
    rc(`PSI_REG_INT_ENABLE, 16'h0000, "enable reset");
    // Frame for another address must stay unanswered, wire at pull-up
    u_host.frame(`PSI_OP_READ, 5'h04, `PSI_REG_INT_ENABLE, 16'h0000, d);
    check("other address", d, 16'hffff);
    rc(`PSI_REG_INT_FLAGS, 16'h0000, "flags reset");
    pin(1'b1);
    wr(`PSI_REG_INT_ENABLE, 16'hffff);
    rc(`PSI_REG_INT_ENABLE, 16'hffff, "enable rw");
    wr(`PSI_REG_INT_FLAGS, 16'hffff);
    rc(`PSI_REG_INT_FLAGS, 16'h0000, "flags write");
    pin(1'b1);
    wr(`PSI_REG_LINK_STATUS, 16'hffff);
    rc(`PSI_REG_LINK_STATUS, 16'h0800, "status ro");
    rc(5'h05, 16'h0000, "unmapped");
    wr(`PSI_REG_INT_ENABLE, 16'h0000);
  endtask

  // Every status field but page at once; the changes also latch their flags
  task automatic t_status;
    @(posedge clk_i);
    {speed, dup, link, an_en, an_done} <= {2'h1, 4'hf};
    {txp, rxp, pol, jab, dg, mdix} <= 6'h3f;
    rc(`PSI_REG_LINK_STATUS, 16'h6c6f, "status all");
    rc(`PSI_REG_INT_FLAGS, 16'h6423, "level flags");
    rc(`PSI_REG_INT_FLAGS, 16'h0000, "flags cleared");
    an_done <= 1'b0;
    rc(`PSI_REG_LINK_STATUS, 16'h6423, "unresolved");
    {an_en, an_done} <= 2'h1;  // Completed flag up, so only forcing can zero pause
    rc(`PSI_REG_LINK_STATUS, 16'h6c63, "forced");
  endtask

  task automatic t_events;
    @(posedge clk_i);
    link <= 1'b0;
    rc(`PSI_REG_INT_FLAGS, 16'h0800, "link lost");
    {page, an_err, wake} <= 3'h7;
    @(posedge clk_i);
    {page, an_err, wake} <= 3'h0;
    rc(`PSI_REG_LINK_STATUS, 16'h7863, "page seen");
    rc(`PSI_REG_LINK_STATUS, 16'h6863, "page clear");
    rc(`PSI_REG_INT_FLAGS, 16'h9040, "pulse flags");
  endtask

  task automatic t_irq;
    wr(`PSI_REG_INT_ENABLE, 16'h0400);
    link <= 1'b1;
    pin(1'b0);
    wr(`PSI_REG_INT_ENABLE, 16'h0000);
    pin(1'b1);
    wr(`PSI_REG_INT_ENABLE, 16'h0400);
    pin(1'b0);
    rc(`PSI_REG_INT_FLAGS, 16'h0400, "link up");
    pin(1'b1);
  endtask

  // New crossover setting waits for the software reset
  task automatic t_xover;
    @(posedge clk_i);
    xcfg <= `PSI_XOVER_MDI;
    rc(`PSI_REG_LINK_STATUS, 16'h6c63, "xover held");
    // Link drop in the soft reset cycle: the set must beat the clear
    srst <= 1'b1;
    link <= 1'b0;
    @(posedge clk_i);
    srst <= 1'b0;
    rc(`PSI_REG_LINK_STATUS, 16'h6823, "xover mdi");
    rc(`PSI_REG_INT_ENABLE, 16'h0000, "soft clear");
    rc(`PSI_REG_INT_FLAGS, 16'h0800, "set wins");
    xcfg <= `PSI_XOVER_MDIX;
    mdix <= 1'b0;
    srst <= 1'b1;
    @(posedge clk_i);
    srst <= 1'b0;
    rc(`PSI_REG_LINK_STATUS, 16'h6863, "xover mdix");
    xcfg <= 2'h2;
    srst <= 1'b1;
    @(posedge clk_i);
    srst <= 1'b0;
    rc(`PSI_REG_LINK_STATUS, 16'h6823, "xover reserved");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog: about two and a half times the expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    summarize();
  end

  initial begin
    arst_n_i = 1'b0;
    {speed, dup, link, an_en, an_done, txp, rxp, pol, jab, dg, mdix} = '0;
    {page, an_err, wake, srst} = 4'h0;
    xcfg = `PSI_XOVER_AUTO;
    fails = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_regs();
    t_status();
    t_events();
    t_irq();
    t_xover();
    summarize();
  end
endmodule
